// File: nvr_pkg.sv
/*
 package for the storage index router: handle ranges, index types, attribute bits,
 configuration layout, status codes, table sizes.
 assumes nothing of its surroundings.
*/
`default_nettype none
package nvr_pkg;
   // ======================================================
   // handle ranges
   localparam logic [31:0] GPIO_BASE     = 32'h01c40000;
   localparam logic [31:0] GPIO_LAST     = 32'h01c4000f;
   localparam logic [31:0] PERI_BASE     = 32'h01c40100;
   localparam logic [31:0] PERI_LAST     = 32'h01c401ff;
   localparam int          GPIO_COUNT    = 16;
   // ======================================================
   // index table sizes
   localparam int          CNT_SLOTS     = 6;
   localparam int          CNT_ORD_SLOTS = 2;
   localparam int          PIN_SLOTS     = 2;
   localparam int          BUF_SLOTS     = 8;
   // ======================================================
   // index types
   localparam logic [2:0]  TYPE_ORDINARY = 3'h0;
   localparam logic [2:0]  TYPE_COUNTER  = 3'h1;
   localparam logic [2:0]  TYPE_BITS     = 3'h2;
   localparam logic [2:0]  TYPE_EXTEND   = 3'h3;
   localparam logic [2:0]  TYPE_PINFAIL  = 3'h4;
   localparam logic [2:0]  TYPE_PINPASS  = 3'h5;
   // ======================================================
   // attribute bits
   localparam int          ATTR_ORDERLY  = 0;
   localparam int          ATTR_PLATCRE  = 1;
   localparam int          ATTR_OWNRD    = 2;
   localparam int          ATTR_OWNWR    = 3;
   localparam int          ATTR_AUTHRD   = 4;
   localparam int          ATTR_AUTHWR   = 5;
   // ======================================================
   // configuration structure
   localparam logic [7:0]  CFG_VERSION   = 8'h01;
   localparam logic [2:0]  CFG_OFS_VER   = 3'h0;
   localparam logic [2:0]  CFG_OFS_BUS   = 3'h1;
   localparam logic [2:0]  CFG_OFS_MEM   = 3'h5;
   localparam logic [2:0]  CFG_LEN       = 3'h6;
   // ======================================================
   // commands and status
   localparam logic [1:0]  CMD_DEFINE    = 2'h0;
   localparam logic [1:0]  CMD_WRITE     = 2'h1;
   localparam logic [1:0]  CMD_READ      = 2'h2;
   localparam logic [1:0]  CMD_UNDEFINE  = 2'h3;
   localparam logic [3:0]  ST_OK         = 4'h0;
   localparam logic [3:0]  ST_UNDEF      = 4'h1;
   localparam logic [3:0]  ST_TYPE       = 4'h2;
   localparam logic [3:0]  ST_ATTR       = 4'h3;
   localparam logic [3:0]  ST_NOSPACE    = 4'h4;
   localparam logic [3:0]  ST_AUTH       = 4'h5;
   localparam logic [3:0]  ST_EXISTS     = 4'h6;
   localparam logic [3:0]  ST_RANGE      = 4'h7;
   localparam logic [3:0]  ST_CFG        = 4'h8;
   // ======================================================
   // states
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_PERI = 4'b0010,
      S_RESP = 4'b0100,
      S_CFGW = 4'b1000
   } nvr_state_t;
endpackage
`default_nettype wire

// File: nvr_router.sv
/*
 storage index router: takes define, write, read and undefine commands on a
 plain command port, keeps the counter, pin, gpio and peripheral index tables,
 drives gpio pins and forwards peripheral accesses byte by byte to a link port.
 assumes one 100 MHz clock, a host that waits for cmdDone before the next
 command, and a serial engine behind the link port that handshakes per byte.
*/
`default_nettype none
module nvr_router (
   input  wire  logic        clock,
   input  wire  logic        rst_n,
   input  wire  logic        cmdValid,
   input  wire  logic [1:0]  cmdCode,
   input  wire  logic [31:0] cmdHandle,
   input  wire  logic [2:0]  cmdType,
   input  wire  logic [5:0]  cmdAttr,
   input  wire  logic [7:0]  cmdSize,
   input  wire  logic [7:0]  cmdOffset,
   input  wire  logic [7:0]  cmdData,
   input  wire  logic        cmdOwnerAuth,
   input  wire  logic        cmdPlatform,
   input  wire  logic        ownerClear,
   output var   logic        cmdDone,
   output var   logic [3:0]  cmdStatus,
   output var   logic [7:0]  rspData,
   input  wire  logic [15:0] gpioIn,
   output var   logic [15:0] gpioOut,
   output var   logic [15:0] gpioOe,
   output var   logic        linkReq,
   output var   logic        linkWrite,
   output var   logic [7:0]  linkAddr,
   output var   logic [7:0]  linkWdata,
   output var   logic [31:0] linkBusCfg,
   input  wire  logic        linkAck,
   input  wire  logic [7:0]  linkRdata
);
   // ======================================================
   // decode helpers
   function automatic logic inGpio(input logic [31:0] h);
      inGpio = (h >= nvr_pkg::GPIO_BASE) && (h <= nvr_pkg::GPIO_LAST);
   endfunction
   function automatic logic inPeri(input logic [31:0] h);
      inPeri = (h >= nvr_pkg::PERI_BASE) && (h <= nvr_pkg::PERI_LAST);
   endfunction

   // ======================================================
   // index tables
   logic [nvr_pkg::CNT_SLOTS-1:0] cntUsed_r;
   logic [nvr_pkg::PIN_SLOTS-1:0] pinUsed_r;
   logic [15:0]                   gpioDef_r;
   logic [15:0]                   gpioPlat_r;
   logic [5:0]                    gpioAttr_r [nvr_pkg::GPIO_COUNT];
   logic                          cfgDef_r;
   logic [7:0]                    cfgVer_r;
   logic [7:0]                    memSize_r;
   logic [7:0]                    cfgHandle_r;
   logic [nvr_pkg::BUF_SLOTS-1:0] bufUsed_r;
   logic [7:0]                    bufHandle_r [nvr_pkg::BUF_SLOTS];
   logic [7:0]                    bufBase_r   [nvr_pkg::BUF_SLOTS];
   logic [7:0]                    bufSize_r   [nvr_pkg::BUF_SLOTS];
   logic [5:0]                    bufAttr_r   [nvr_pkg::BUF_SLOTS];
   logic [8:0]                    memUsed_r;
   nvr_pkg::nvr_state_t           state_r;

   // ======================================================
   // combinational lookup of the command target
   logic [3:0] gIdx;
   logic [2:0] freeCnt;
   logic       cntFull;
   logic       cntOrdOk;
   logic       pinFull;
   logic [2:0] freeBuf;
   logic       bufFull;
   logic [2:0] hitBuf;
   logic       bufHit;
   logic       isCfg;
   logic       memFits;
   logic       bufAuthRd;
   logic       bufAuthWr;
   logic       gpioAuthRd;
   logic       gpioAuthWr;

   assign gIdx = cmdHandle[3:0];
   assign isCfg = cfgDef_r && (cmdHandle[7:0] == cfgHandle_r);

   always_comb begin
      freeCnt = 3'h0;
      cntFull = 1'b1;
      freeBuf = 3'h0;
      bufFull = 1'b1;
      hitBuf  = 3'h0;
      bufHit  = 1'b0;
      // counters below CNT_ORD_SLOTS are the ones allowed to be orderly
      for (int i = nvr_pkg::CNT_SLOTS - 1; i >= 0; i--) begin
         if (!cntUsed_r[i] && (!cmdAttr[nvr_pkg::ATTR_ORDERLY] || i < nvr_pkg::CNT_ORD_SLOTS)) begin
            freeCnt = 3'(i);
            cntFull = 1'b0;
         end
      end
      for (int i = nvr_pkg::BUF_SLOTS - 1; i >= 0; i--) begin
         if (!bufUsed_r[i]) begin
            freeBuf = 3'(i);
            bufFull = 1'b0;
         end
         if (bufUsed_r[i] && bufHandle_r[i] == cmdHandle[7:0]) begin
            hitBuf = 3'(i);
            bufHit = 1'b1;
         end
      end
   end

   assign cntOrdOk   = !cntFull;
   assign pinFull    = &pinUsed_r;
   assign memFits    = ({1'b0, cmdSize} + memUsed_r) <= {1'b0, memSize_r};
   assign bufAuthRd  = bufAttr_r[hitBuf][nvr_pkg::ATTR_AUTHRD] ||
                       (bufAttr_r[hitBuf][nvr_pkg::ATTR_OWNRD] && cmdOwnerAuth);
   assign bufAuthWr  = bufAttr_r[hitBuf][nvr_pkg::ATTR_AUTHWR] ||
                       (bufAttr_r[hitBuf][nvr_pkg::ATTR_OWNWR] && cmdOwnerAuth);
   assign gpioAuthRd = gpioAttr_r[gIdx][nvr_pkg::ATTR_AUTHRD] ||
                       (gpioAttr_r[gIdx][nvr_pkg::ATTR_OWNRD] && cmdOwnerAuth);
   assign gpioAuthWr = gpioAttr_r[gIdx][nvr_pkg::ATTR_AUTHWR] ||
                       (gpioAttr_r[gIdx][nvr_pkg::ATTR_OWNWR] && cmdOwnerAuth);

   // ======================================================
   // verdict on a command in idle
   logic [3:0] verdict;
   logic       goLink;
   logic       goCfg;
   always_comb begin
      verdict = nvr_pkg::ST_OK;
      goLink  = 1'b0;
      goCfg   = 1'b0;
      if (inGpio(cmdHandle)) begin
         if (cmdCode == nvr_pkg::CMD_DEFINE) begin
            if (gpioDef_r[gIdx]) verdict = nvr_pkg::ST_EXISTS;
         end else if (!gpioDef_r[gIdx]) begin
            verdict = nvr_pkg::ST_UNDEF;
         end else if (cmdCode == nvr_pkg::CMD_WRITE && !gpioAuthWr) begin
            verdict = nvr_pkg::ST_AUTH;
         end else if (cmdCode == nvr_pkg::CMD_READ && !gpioAuthRd) begin
            verdict = nvr_pkg::ST_AUTH;
         end
      end else if (inPeri(cmdHandle)) begin
         if (cmdCode == nvr_pkg::CMD_DEFINE) begin
            if (cmdType != nvr_pkg::TYPE_ORDINARY) verdict = nvr_pkg::ST_TYPE;
            else if (cmdAttr[nvr_pkg::ATTR_ORDERLY]) verdict = nvr_pkg::ST_ATTR;
            else if (isCfg || bufHit) verdict = nvr_pkg::ST_EXISTS;
            else if (!cfgDef_r) begin
               // first define in the range creates the configuration index
               if (cmdPlatform && !cmdAttr[nvr_pkg::ATTR_PLATCRE]) verdict = nvr_pkg::ST_ATTR;
               else goCfg = 1'b1;
            end else if (bufFull) verdict = nvr_pkg::ST_NOSPACE;
            else if (memSize_r != 8'h00 && !memFits) verdict = nvr_pkg::ST_NOSPACE;
         end else if (cmdCode == nvr_pkg::CMD_UNDEFINE) begin
            if (!bufHit && !isCfg) verdict = nvr_pkg::ST_UNDEF;
         end else if (isCfg) begin
            if (cmdCode == nvr_pkg::CMD_WRITE && cmdOffset[2:0] == nvr_pkg::CFG_OFS_VER &&
                cmdData != nvr_pkg::CFG_VERSION) verdict = nvr_pkg::ST_CFG;
            else if (cmdOffset >= {5'h00, nvr_pkg::CFG_LEN}) verdict = nvr_pkg::ST_RANGE;
         end else if (!bufHit) verdict = nvr_pkg::ST_UNDEF;
         else if (cfgVer_r != nvr_pkg::CFG_VERSION) verdict = nvr_pkg::ST_CFG;
         else if (cmdOffset >= bufSize_r[hitBuf]) verdict = nvr_pkg::ST_RANGE;
         else if (cmdCode == nvr_pkg::CMD_WRITE && !bufAuthWr) verdict = nvr_pkg::ST_AUTH;
         else if (cmdCode == nvr_pkg::CMD_READ && !bufAuthRd) verdict = nvr_pkg::ST_AUTH;
         else goLink = 1'b1;
      end else if (cmdCode == nvr_pkg::CMD_DEFINE) begin
         if (cmdType == nvr_pkg::TYPE_COUNTER && !cntOrdOk) verdict = nvr_pkg::ST_NOSPACE;
         else if ((cmdType == nvr_pkg::TYPE_PINFAIL || cmdType == nvr_pkg::TYPE_PINPASS) && pinFull)
            verdict = nvr_pkg::ST_NOSPACE;
      end
   end

   wire logic accept = (state_r == nvr_pkg::S_IDLE) && cmdValid && (verdict == nvr_pkg::ST_OK);
   wire logic reject = (state_r == nvr_pkg::S_IDLE) && cmdValid && (verdict != nvr_pkg::ST_OK);

   // ======================================================
   // pin synchroniser: a new level counts once stages two and three agree
   logic [15:0] pinS1_r, pinS2_r, pinS3_r, pinLvl_r;
   always_ff @(posedge clock) begin
      pinS1_r  <= gpioIn;
      pinS2_r  <= pinS1_r;
      pinS3_r  <= pinS2_r;
      pinLvl_r <= (pinS2_r & pinS3_r) | (pinLvl_r & (pinS2_r | pinS3_r));
   end

   // ======================================================
   // control sequence
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_r <= nvr_pkg::S_IDLE;
      end else begin
         unique case (state_r)
            nvr_pkg::S_IDLE: begin
               if (cmdValid && verdict == nvr_pkg::ST_OK && goLink) state_r <= nvr_pkg::S_PERI;
               else if (cmdValid && verdict == nvr_pkg::ST_OK && goCfg) state_r <= nvr_pkg::S_CFGW;
               else if (cmdValid) state_r <= nvr_pkg::S_RESP;
            end
            // hold the answer until the link acknowledges the byte
            nvr_pkg::S_PERI: if (linkAck) state_r <= nvr_pkg::S_RESP;
            nvr_pkg::S_CFGW: state_r <= nvr_pkg::S_RESP;
            nvr_pkg::S_RESP: state_r <= nvr_pkg::S_IDLE;
         endcase
      end
   end

   // ======================================================
   // response port
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cmdDone   <= 1'b0;
         cmdStatus <= nvr_pkg::ST_OK;
         rspData   <= 8'h00;
      end else begin
         cmdDone <= (state_r == nvr_pkg::S_RESP);
         if (reject) cmdStatus <= verdict;
         else if (accept) cmdStatus <= nvr_pkg::ST_OK;
         if (accept && cmdCode == nvr_pkg::CMD_READ) begin
            if (inGpio(cmdHandle)) rspData <= {7'h00, pinLvl_r[gIdx]};
            else if (isCfg) begin
               unique case (cmdOffset[2:0])
                  3'h0:    rspData <= cfgVer_r;
                  3'h1:    rspData <= linkBusCfg[7:0];
                  3'h2:    rspData <= linkBusCfg[15:8];
                  3'h3:    rspData <= linkBusCfg[23:16];
                  3'h4:    rspData <= linkBusCfg[31:24];
                  default: rspData <= memSize_r;
               endcase
            end
         end else if (state_r == nvr_pkg::S_PERI && linkAck && !linkWrite) begin
            rspData <= linkRdata;
         end
      end
   end

   // ======================================================
   // counter and pin tables: slot bookkeeping only, values live in storage
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cntUsed_r <= '0;
         pinUsed_r <= '0;
      end else if (accept && cmdCode == nvr_pkg::CMD_DEFINE && !inGpio(cmdHandle) && !inPeri(cmdHandle)) begin
         if (cmdType == nvr_pkg::TYPE_COUNTER) begin
            cntUsed_r[freeCnt] <= 1'b1;
         end
         if (cmdType == nvr_pkg::TYPE_PINFAIL || cmdType == nvr_pkg::TYPE_PINPASS)
            pinUsed_r[pinUsed_r[0] ? 1 : 0] <= 1'b1;
      end
   end

   // ======================================================
   // gpio index table and pins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         gpioDef_r  <= '0;
         gpioPlat_r <= '0;
         gpioOut    <= '0;
         gpioOe     <= '0;
         for (int i = 0; i < nvr_pkg::GPIO_COUNT; i++) gpioAttr_r[i] <= '0;
      end else begin
         if (ownerClear) begin
            gpioDef_r <= gpioDef_r & gpioPlat_r;
            gpioOe    <= gpioOe & gpioPlat_r;
         end else if (accept && inGpio(cmdHandle)) begin
            if (cmdCode == nvr_pkg::CMD_DEFINE) begin
               gpioDef_r[gIdx]  <= 1'b1;
               gpioPlat_r[gIdx] <= cmdPlatform;
               gpioAttr_r[gIdx] <= cmdAttr;
            end else if (cmdCode == nvr_pkg::CMD_UNDEFINE) begin
               gpioDef_r[gIdx] <= 1'b0;
               gpioOe[gIdx]    <= 1'b0;
            end else if (cmdCode == nvr_pkg::CMD_WRITE) begin
               gpioOut[gIdx] <= cmdData[0];
               gpioOe[gIdx]  <= 1'b1;
            end
         end
      end
   end

   // ======================================================
   // configuration index
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cfgDef_r    <= 1'b0;
         cfgHandle_r <= 8'h00;
         cfgVer_r    <= 8'h00;
         memSize_r   <= 8'h00;
         linkBusCfg  <= 32'h00000000;
      end else if (accept && inPeri(cmdHandle)) begin
         if (goCfg) begin
            cfgDef_r    <= 1'b1;
            cfgHandle_r <= cmdHandle[7:0];
         end else if (isCfg && cmdCode == nvr_pkg::CMD_UNDEFINE) begin
            cfgDef_r <= 1'b0;
         end else if (isCfg && cmdCode == nvr_pkg::CMD_WRITE) begin
            unique case (cmdOffset[2:0])
               3'h0:    cfgVer_r <= cmdData;
               3'h1:    linkBusCfg[7:0]   <= cmdData;
               3'h2:    linkBusCfg[15:8]  <= cmdData;
               3'h3:    linkBusCfg[23:16] <= cmdData;
               3'h4:    linkBusCfg[31:24] <= cmdData;
               default: memSize_r <= cmdData;
            endcase
         end
      end
   end

   // ======================================================
   // data buffer table: memory carved linearly, freed space not reclaimed
   // until every buffer is gone, a simple trade against a full allocator
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bufUsed_r <= '0;
         memUsed_r <= 9'h000;
         for (int i = 0; i < nvr_pkg::BUF_SLOTS; i++) begin
            bufHandle_r[i] <= 8'h00;
            bufBase_r[i]   <= 8'h00;
            bufSize_r[i]   <= 8'h00;
            bufAttr_r[i]   <= 6'h00;
         end
      end else if (accept && inPeri(cmdHandle) && !goCfg && !isCfg) begin
         if (cmdCode == nvr_pkg::CMD_DEFINE) begin
            bufUsed_r[freeBuf]   <= 1'b1;
            bufHandle_r[freeBuf] <= cmdHandle[7:0];
            bufBase_r[freeBuf]   <= memUsed_r[7:0];
            bufSize_r[freeBuf]   <= cmdSize;
            bufAttr_r[freeBuf]   <= cmdAttr;
            if (memSize_r != 8'h00) memUsed_r <= memUsed_r + {1'b0, cmdSize};
         end else if (cmdCode == nvr_pkg::CMD_UNDEFINE) begin
            bufUsed_r[hitBuf] <= 1'b0;
            if (bufUsed_r == (8'h01 << hitBuf)) memUsed_r <= 9'h000;
         end
      end
   end

   // ======================================================
   // link request: one byte per command, data copied untouched
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         linkReq   <= 1'b0;
         linkWrite <= 1'b0;
         linkAddr  <= 8'h00;
         linkWdata <= 8'h00;
      end else if (accept && goLink) begin
         linkReq   <= 1'b1;
         linkWrite <= (cmdCode == nvr_pkg::CMD_WRITE);
         linkAddr  <= (memSize_r != 8'h00) ? 8'(bufBase_r[hitBuf] + cmdOffset) : cmdOffset;
         linkWdata <= cmdData;
      end else if (state_r == nvr_pkg::S_PERI && linkAck) begin
         linkReq <= 1'b0;
      end
   end
endmodule // nvr_router
`default_nettype wire

// File: nvr_router_props.sv
/* checker for the storage index router, bound into nvr_router.
 assumes the host waits for cmdDone before a new command. */
`default_nettype none
module nvr_router_props (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        cmdValid,
   input wire logic [1:0]  cmdCode,
   input wire logic [31:0] cmdHandle,
   input wire logic [2:0]  cmdType,
   input wire logic [5:0]  cmdAttr,
   input wire logic        cmdDone,
   input wire logic [3:0]  cmdStatus,
   input wire logic [7:0]  rspData,
   input wire logic [15:0] gpioOe,
   input wire logic        linkReq,
   input wire logic        linkWrite,
   input wire logic [7:0]  linkAddr,
   input wire logic [7:0]  linkWdata,
   input wire logic        linkAck,
   input wire logic [7:0]  linkRdata
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // helpers: peripheral defines answer locally
   wire logic inPeri = cmdHandle >= nvr_pkg::PERI_BASE && cmdHandle <= nvr_pkg::PERI_LAST;
   wire logic periDef = cmdValid && inPeri && cmdCode == nvr_pkg::CMD_DEFINE;
   sequence s_rd_ack; linkReq && !linkWrite && linkAck; endsequence
   sequence s_wr_ack; linkReq && linkWrite && linkAck; endsequence
   property p_rst; disable iff (1'b0) !rst_n |=> !cmdDone && !linkReq && gpioOe == 16'h0; endproperty
   property p_pulse; cmdDone |=> !cmdDone; endproperty
   property p_hold; linkReq && !linkAck |=> linkReq && $stable({linkWrite, linkAddr, linkWdata}); endproperty
   property p_drop; linkReq && linkAck |=> !linkReq; endproperty
   property p_early; linkReq |-> !cmdDone; endproperty
   property p_rd; s_rd_ack |-> ##2 cmdDone && rspData == $past(linkRdata, 2); endproperty
   property p_wr; s_wr_ack |-> ##2 cmdDone; endproperty
   property p_local; cmdValid && !inPeri |-> ##2 cmdDone && !linkReq; endproperty
   property p_type; periDef && cmdType != nvr_pkg::TYPE_ORDINARY |-> ##2 cmdDone && cmdStatus != nvr_pkg::ST_OK;
   endproperty
   property p_ord; periDef && cmdAttr[nvr_pkg::ATTR_ORDERLY] |-> ##2 cmdDone && cmdStatus != nvr_pkg::ST_OK;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
   a_pulse: assert property (p_pulse) else $error("response longer than one cycle");
   a_hold: assert property (p_hold) else $error("link request changed before ack");
   a_drop: assert property (p_drop) else $error("link request held after ack");
   a_early: assert property (p_early) else $error("response while link busy");
   a_rd: assert property (p_rd) else $error("read byte not returned");
   a_wr: assert property (p_wr) else $error("write response late");
   a_local: assert property (p_local) else $error("local command misrouted");
   a_type: assert property (p_type) else $error("non ordinary peripheral index taken");
   a_ord: assert property (p_ord) else $error("orderly peripheral index taken");
endmodule // nvr_router_props
bind nvr_router nvr_router_props nvr_router_props_i (.clock(clock), .rst_n(rst_n), .cmdValid(cmdValid),
   .cmdCode(cmdCode), .cmdHandle(cmdHandle), .cmdType(cmdType), .cmdAttr(cmdAttr), .cmdDone(cmdDone),
   .cmdStatus(cmdStatus), .rspData(rspData), .gpioOe(gpioOe), .linkReq(linkReq), .linkWrite(linkWrite),
   .linkAddr(linkAddr), .linkWdata(linkWdata), .linkAck(linkAck), .linkRdata(linkRdata));
`default_nettype wire

// File: nvr_link_model.sv
/* serial memory engine model behind the link port.
 assumes one request at a time, held until the edge after ack. */
`default_nettype none
module nvr_link_model (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [3:0] ackDelay,
   input  wire logic       linkReq,
   input  wire logic       linkWrite,
   input  wire logic [7:0] linkAddr,
   input  wire logic [7:0] linkWdata,
   output var  logic       linkAck,
   output var  logic [7:0] linkRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   logic [3:0] waitCnt;
   // ==========================================
   // ack ackDelay+1 cycles after the request rises; read data toggles outside ack so stale bytes show
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         linkAck <= 1'b0;
         waitCnt <= 4'h0;
         linkRdata <= 8'h00;
      end else begin
         linkAck <= 1'b0;
         linkRdata <= ~linkRdata;
         if (linkReq && !linkAck) begin
            waitCnt <= waitCnt + 4'h1;
            if (waitCnt == ackDelay) begin
               linkAck <= 1'b1;
               waitCnt <= 4'h0;
               linkRdata <= mem[linkAddr];
               if (linkWrite) mem[linkAddr] <= linkWdata;
            end
         end
      end
   end
endmodule // nvr_link_model
`default_nettype wire

// File: tb_nvr_router.sv
/* testbench for the storage index router with a link engine model.
 assumes the checker is bound in by its own file. */
`default_nettype none
module tb_nvr_router;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, rst_n, cmdValid, cmdOwnerAuth, cmdPlatform, ownerClear, cmdDone, linkReq, linkWrite, linkAck;
   logic [1:0]  cmdCode;
   logic [2:0]  cmdType;
   logic [5:0]  cmdAttr;
   logic [3:0]  cmdStatus, ackDelay;
   logic [7:0]  cmdSize, cmdOffset, cmdData, rspData, linkAddr, linkWdata, linkRdata;
   logic [15:0] gpioIn, gpioOut, gpioOe;
   logic [31:0] cmdHandle, linkBusCfg;
   int          failures = 0, num_checks = 0, cycles = 0;
   localparam logic [31:0] BUF0 = nvr_pkg::PERI_BASE + 32'h10;
   nvr_router nvr_router_i (.clock(clock), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
      .cmdHandle(cmdHandle), .cmdType(cmdType), .cmdAttr(cmdAttr), .cmdSize(cmdSize), .cmdOffset(cmdOffset),
      .cmdData(cmdData), .cmdOwnerAuth(cmdOwnerAuth), .cmdPlatform(cmdPlatform), .ownerClear(ownerClear),
      .cmdDone(cmdDone), .cmdStatus(cmdStatus), .rspData(rspData), .gpioIn(gpioIn), .gpioOut(gpioOut),
      .gpioOe(gpioOe), .linkReq(linkReq), .linkWrite(linkWrite), .linkAddr(linkAddr), .linkWdata(linkWdata),
      .linkBusCfg(linkBusCfg), .linkAck(linkAck), .linkRdata(linkRdata));
   nvr_link_model nvr_link_model_i (.clock(clock), .rst_n(rst_n), .ackDelay(ackDelay), .linkReq(linkReq),
      .linkWrite(linkWrite), .linkAddr(linkAddr), .linkWdata(linkWdata), .linkAck(linkAck), .linkRdata(linkRdata));
   // ==========================================
   // clock, and a cycle ceiling far above the test length
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end
   task automatic results();
      if (failures == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one command; waits for the one-cycle response, bounded
   task automatic cmd(input logic [1:0] c, input logic [31:0] h, input logic [2:0] t, input logic [5:0] a,
                      input logic [7:0] s, input logic [7:0] o, input logic [7:0] d);
      @(posedge clock);
      cmdValid <= 1'b1;
      cmdCode <= c;
      cmdHandle <= h;
      cmdType <= t;
      cmdAttr <= a;
      cmdSize <= s;
      cmdOffset <= o;
      cmdData <= d;
      @(posedge clock);
      cmdValid <= 1'b0;
      for (int n = 0; n < 100 && cmdDone !== 1'b1; n++) @(posedge clock);
      chk(cmdDone, 1'b1);
   endtask
   task automatic t_counters();
      for (int i = 0; i < 8; i++) begin
         cmd(nvr_pkg::CMD_DEFINE, 32'h01000000 + 32'(i), (i < 6) ? nvr_pkg::TYPE_COUNTER :
             (i == 6) ? nvr_pkg::TYPE_PINFAIL : nvr_pkg::TYPE_PINPASS, (i < 2) ? 6'h01 : 6'h00, 8'h08, 8'h0, 8'h0);
         chk(cmdStatus, nvr_pkg::ST_OK);
      end
   endtask
   task automatic t_gpio();
      cmdPlatform <= 1'b0;
      cmd(nvr_pkg::CMD_WRITE, nvr_pkg::GPIO_LAST, 3'h0, 6'h00, 8'h0, 8'h0, 8'h01);
      chk(cmdStatus, nvr_pkg::ST_UNDEF);
      cmd(nvr_pkg::CMD_DEFINE, nvr_pkg::GPIO_LAST, 3'h0, 6'h30, 8'h01, 8'h0, 8'h0);
      chk(cmdStatus, nvr_pkg::ST_OK);
      gpioIn <= 16'h8000;
      cmd(nvr_pkg::CMD_WRITE, nvr_pkg::GPIO_LAST, 3'h0, 6'h00, 8'h0, 8'h0, 8'h01);
      @(posedge clock);
      chk({gpioOe, gpioOut}, 32'h80008000);
      cmd(nvr_pkg::CMD_READ, nvr_pkg::GPIO_LAST, 3'h0, 6'h00, 8'h0, 8'h0, 8'h0);
      chk(rspData[0], 1'b1);
      ownerClear <= 1'b1;
      @(posedge clock);
      ownerClear <= 1'b0;
      cmd(nvr_pkg::CMD_READ, nvr_pkg::GPIO_LAST, 3'h0, 6'h00, 8'h0, 8'h0, 8'h0);
      chk({cmdStatus, gpioOe}, {nvr_pkg::ST_UNDEF, 16'h0});
   endtask
   task automatic t_config();
      logic [5:0] bad [3] = '{6'h00, 6'h03, 6'h02};
      cmdPlatform <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         cmd(nvr_pkg::CMD_DEFINE, nvr_pkg::PERI_BASE, (i == 2) ? nvr_pkg::TYPE_COUNTER : nvr_pkg::TYPE_ORDINARY,
             (i < 3) ? bad[i] : 6'h02, 8'(nvr_pkg::CFG_LEN), 8'h0, 8'h0);
         chk(cmdStatus !== nvr_pkg::ST_OK, i < 3);
      end
      cmd(nvr_pkg::CMD_WRITE, nvr_pkg::PERI_BASE, 3'h0, 6'h0, 8'h0, 8'h0, 8'h02);
      chk(cmdStatus, nvr_pkg::ST_CFG);
      for (int i = 0; i < 6; i++) begin
         cmd(nvr_pkg::CMD_WRITE, nvr_pkg::PERI_BASE, 3'h0, 6'h0, 8'h0, 8'(i), (i == 0) ? 8'h01 : 8'(i * 17 + 47));
         chk(cmdStatus, nvr_pkg::ST_OK);
      end
      chk(linkBusCfg, 32'h73625140);
   endtask
   task automatic t_buffers();
      cmdOwnerAuth <= 1'b1;
      cmd(nvr_pkg::CMD_DEFINE, BUF0, 3'h0, 6'h0c, 8'h10, 8'h0, 8'h0);
      chk(cmdStatus, nvr_pkg::ST_OK);
      ackDelay <= 4'h5;
      cmd(nvr_pkg::CMD_WRITE, BUF0, 3'h0, 6'h0, 8'h0, 8'h03, 8'ha5);
      chk({cmdStatus, nvr_link_model_i.mem[3]}, {nvr_pkg::ST_OK, 8'ha5});
      cmd(nvr_pkg::CMD_READ, BUF0, 3'h0, 6'h0, 8'h0, 8'h03, 8'h0);
      chk(rspData, 8'ha5);
      cmdOwnerAuth <= 1'b0;
      cmd(nvr_pkg::CMD_READ, BUF0, 3'h0, 6'h0, 8'h0, 8'h03, 8'h0);
      chk(cmdStatus, nvr_pkg::ST_AUTH);
      cmd(nvr_pkg::CMD_DEFINE, BUF0 + 32'h1, 3'h0, 6'h0c, 8'h75, 8'h0, 8'h0);
      chk(cmdStatus, nvr_pkg::ST_NOSPACE);
      cmd(nvr_pkg::CMD_DEFINE, BUF0 + 32'h1, 3'h0, 6'h2c, 8'h74, 8'h0, 8'h0);
      chk(cmdStatus, nvr_pkg::ST_OK);
      cmd(nvr_pkg::CMD_WRITE, BUF0 + 32'h1, 3'h0, 6'h0, 8'h0, 8'h0, 8'h5a);
      chk(nvr_link_model_i.mem[16], 8'h5a);
      cmd(nvr_pkg::CMD_UNDEFINE, BUF0, 3'h0, 6'h0, 8'h0, 8'h0, 8'h0);
      cmd(nvr_pkg::CMD_READ, BUF0, 3'h0, 6'h0, 8'h0, 8'h0, 8'h0);
      chk(cmdStatus, nvr_pkg::ST_UNDEF);
   endtask
   // ==========================================
   // main sequence
   initial begin
      {rst_n, cmdValid, cmdCode, cmdHandle, cmdType, cmdAttr, cmdSize, cmdOffset, cmdData} = '0;
      {cmdOwnerAuth, ownerClear, gpioIn, ackDelay} = '0;
      cmdPlatform = 1'b1;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      t_counters();
      t_gpio();
      t_config();
      t_buffers();
      results();
   end
endmodule // tb_nvr_router
`default_nettype wire
